// file: test/spi_host_model.sv
`timescale 1ns/100ps
module spi_host_model (
    output logic      sck,
    output logic      cs_n,
    output logic      hold_n,
    output logic      si,
    output logic      si_en,
    input  wire logic so_pin,
    input  wire logic io0_pin,
    input  wire logic oe_any
);
    logic hold_oe;

    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        hold_n = 1'b1;
        si = 1'b0;
        si_en = 1'b1;
        hold_oe = 1'b0;
    end

    // pause with select low and clock low, wiggle clock and data meanwhile
    task automatic pause();
        #1 hold_n = 1'b0;
        repeat (3) begin
            #3 sck = 1'b1;
            si = ~si;
            hold_oe = hold_oe | oe_any;
            #3 sck = 1'b0;
        end
        #3 hold_n = 1'b1;
    endtask : pause

    // one framed transfer of n clocks, capturing on rising edges
    task automatic frame(input int n, input logic [15:0] din, input bit dual, input bit cpol,
                         input int hold_at, output logic [15:0] cap);
        cap = 16'h0000;
        sck = cpol;
        si_en = !dual;
        #10 cs_n = 1'b0;
        #10;
        for (int i = 0; i < n; i++) begin
            sck = 1'b0;
            if (i == hold_at) pause();
            si = din[15-i];
            #3 sck = 1'b1;
            cap = dual ? {cap[13:0], so_pin, io0_pin} : {cap[14:0], so_pin};
            #3;
        end
        sck = cpol;
        #10 cs_n = 1'b1;
        si_en = 1'b1;
    endtask : frame

    // clock activity while deselected
    task automatic idle(input int n);
        repeat (n) begin
            #3 sck = 1'b1;
            si = ~si;
            #3 sck = 1'b0;
        end
    endtask : idle
endmodule : spi_host_model

// file: test/test_serial_flash_spi_front_end.sv
`timescale 1ns/100ps
module test_serial_flash_spi_front_end;
    logic core_clk, sys_rst, sck, cs_n, hold_n, si, si_en, junk;
    logic d0, oe0, d1, oe1, io0, io1, tx_load, out_en, dual_en, busy;
    logic rx_valid, frame_start, frame_end, selected, standby;
    logic [7:0]  tx_byte, rx_byte;
    logic [15:0] cap;
    int fail_count, comparisons, n_rx, n_fs, n_fe, n_bad, r0, f0, e0;

    // a released pin shows a changing level, not the last one
    always @(sck) junk <= ~junk;
    assign io0 = oe0 ? d0 : (si_en ? si : junk);
    assign io1 = oe1 ? d1 : junk;

    always #25 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        if (rx_valid === 1'b1) n_rx <= n_rx + 1;
        if (frame_start === 1'b1) n_fs <= n_fs + 1;
        if (frame_end === 1'b1) n_fe <= n_fe + 1;
        if (cs_n && (oe0 !== 1'b0 || oe1 !== 1'b0)) n_bad <= n_bad + 1;
    end

    serial_flash_spi_front_end DUT (.core_clk(core_clk), .sys_rst(sys_rst), .sck(sck),
        .cs_n(cs_n), .hold_n(hold_n), .dual_data_bit_zero_in(io0),
        .dual_data_bit_zero(d0), .dual_data_bit_zero_oe(oe0), .dual_data_bit_one(d1),
        .dual_data_bit_one_oe(oe1), .tx_byte(tx_byte), .tx_load(tx_load), .out_en(out_en),
        .dual_en(dual_en), .busy(busy), .rx_byte(rx_byte), .rx_valid(rx_valid),
        .frame_start(frame_start), .frame_end(frame_end), .selected(selected),
        .standby(standby));
    spi_host_model host (.sck(sck), .cs_n(cs_n), .hold_n(hold_n), .si(si), .si_en(si_en),
        .so_pin(io1), .io0_pin(io0), .oe_any(oe0 | oe1));

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic complete_run();
        if (fail_count == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run

    task automatic prep(input logic oe, input logic de, input logic [7:0] tx);
        @(posedge core_clk);
        out_en <= oe;
        dual_en <= de;
        tx_byte <= tx;
        tx_load <= 1'b1;
        @(posedge core_clk);
        tx_load <= 1'b0;
        repeat (4) @(posedge core_clk);
        r0 = n_rx;
        f0 = n_fs;
        e0 = n_fe;
    endtask : prep

    task automatic settle();
        repeat (8) @(posedge core_clk);
    endtask : settle

    task automatic sc_receive();
        prep(1'b0, 1'b0, 8'h00);
        host.frame(8, 16'hA500, 1'b0, 1'b0, 99, cap);
        settle();
        check(16'(n_rx - r0), 16'h0001);
        check(16'(rx_byte), 16'h00A5);
        check(16'(n_fs - f0), 16'h0001);
        check(16'(n_fe - e0), 16'h0001);
    endtask : sc_receive

    task automatic sc_abort();
        prep(1'b0, 1'b0, 8'h00);
        host.frame(4, 16'hF000, 1'b0, 1'b0, 99, cap);
        settle();
        host.frame(8, 16'h9600, 1'b0, 1'b0, 99, cap);
        settle();
        check(16'(n_rx - r0), 16'h0001);
        check(16'(rx_byte), 16'h0096);
        check(16'(n_fe - e0), 16'h0002);
    endtask : sc_abort

    task automatic sc_hold();
        prep(1'b1, 1'b0, 8'h00);
        host.frame(8, 16'h6900, 1'b0, 1'b0, 3, cap);
        settle();
        check(16'(rx_byte), 16'h0069);
        check(16'(host.hold_oe), 16'h0000);
    endtask : sc_hold

    task automatic sc_reads();
        prep(1'b1, 1'b0, 8'h3C);
        host.frame(16, 16'h5A00, 1'b0, 1'b1, 99, cap);
        settle();
        check(16'(cap[7:0]), 16'h003C);
        prep(1'b1, 1'b1, 8'hC6);
        // dual mode settles after two rising edges, then four pairs follow
        host.frame(6, 16'h0000, 1'b1, 1'b0, 99, cap);
        settle();
        check(16'(cap[7:0]), 16'h00C6);
    endtask : sc_reads

    task automatic sc_deselect();
        prep(1'b1, 1'b0, 8'h00);
        host.idle(8);
        settle();
        check(16'(n_rx - r0), 16'h0000);
        check(16'(n_fs - f0), 16'h0000);
        check(16'(standby), 16'h0001);
    endtask : sc_deselect

    task automatic sc_busy();
        @(posedge core_clk);
        busy <= 1'b1;
        host.frame(8, 16'h1200, 1'b0, 1'b0, 99, cap);
        settle();
        check(16'(standby), 16'h0000);
        check(16'(selected), 16'h0000);
        busy <= 1'b0;
        repeat (4) @(posedge core_clk);
        check(16'(standby), 16'h0001);
    endtask : sc_busy

    initial begin
        core_clk = 1'b0;
        sys_rst = 1'b1;
        junk = 1'b0;
        {tx_load, out_en, dual_en, busy, tx_byte} = '0;
        {fail_count, comparisons, n_rx, n_fs, n_fe, n_bad} = '0;
        repeat (16) @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge core_clk);
        sc_receive();
        sc_abort();
        sc_hold();
        sc_reads();
        sc_deselect();
        sc_busy();
        check(16'(n_bad), 16'h0000);
        complete_run();
    end

    initial begin
        #1000000;
        fail_count++;
        complete_run();
    end
endmodule : test_serial_flash_spi_front_end

// file: verilog/flash_link_pkg.sv
package flash_link_pkg;

    // serial word geometry
    localparam int BYTE_BITS      = 8;
    localparam int DUAL_LANES     = 2;
    localparam int MODE_DUAL_IDX  = 0;
    localparam int MODE_OE_IDX    = 1;
    localparam int MODE_W         = 2;
    localparam int CDC_CS_IDX     = 1;
    localparam int CDC_TGL_IDX    = 0;
    localparam int CDC_W          = 2;

    // link and core timing figures
    localparam int SCK_MAX_MHZ    = 104;
    localparam int CORE_CLK_MHZ   = 20;

    // select-side power state, one-hot
    typedef enum logic [2:0] {
        ST_SELECTED  = 3'h1,
        ST_FINISHING = 3'h2,
        ST_STANDBY   = 3'h4
    } power_state_e;

endpackage : flash_link_pkg

// file: verilog/serial_flash_spi_front_end.sv
// How it works
// R1: falling chip select starts a fresh command sequence.
// R2: rising chip select ends the current command sequence.
// R3: deselected device rests in standby with output pins released.
// R4: serial input is ignored entirely while deselected.
// R5: after a frame ends, standby waits until the internal busy cycle finishes.
// R6: input bits are sampled on each rising serial clock edge; in dual mode rx_sh_r and rx_cnt_r do not load.
// R7: output bits are launched on falling serial clock edges.
// R8: dual reads drive both data pins, two bits per falling edge.
// R9: clock may idle low or high; sampling stays on rising edges.
// R10: host keeps the serial clock at or below 104 MHz; the test host model clocks with a 6 ns period, about 167 MHz.
// R11: pause input freezes clock and data handling and releases outputs; mode_r and mode_meta_r still load on sck rising edges in pause.
// R12: pause starts selected with clock low and never touches busy cycles.
// R13: bytes travel most significant bit first from the first rising edge.
// R14: chip select rising mid-byte aborts it; next frame starts at bit one.
`timescale 1ns/100ps
module serial_flash_spi_front_end
    import flash_link_pkg::*;
#(
    parameter int DATA_W = BYTE_BITS
) (
    input  wire logic              core_clk,
    input  wire logic              sys_rst,
    input  wire logic              sck,
    input  wire logic              cs_n,
    input  wire logic              hold_n,
    input  wire logic              dual_data_bit_zero_in,
    output logic                   dual_data_bit_zero,
    output logic                   dual_data_bit_zero_oe,
    output logic                   dual_data_bit_one,
    output logic                   dual_data_bit_one_oe,
    input  wire logic [DATA_W-1:0] tx_byte,
    input  wire logic              tx_load,
    input  wire logic              out_en,
    input  wire logic              dual_en,
    input  wire logic              busy,
    output logic      [DATA_W-1:0] rx_byte,
    output logic                   rx_valid,
    output logic                   frame_start,
    output logic                   frame_end,
    output logic                   selected,
    output logic                   standby
);
    localparam int CNT_W = $clog2(DATA_W);
    localparam logic [CNT_W-1:0] CNT_ONE   = CNT_W'(1);
    localparam logic [CNT_W-1:0] DUAL_LAST = CNT_W'(DATA_W / DUAL_LANES - 1);

    if (DATA_W < 2 * DUAL_LANES || (DATA_W & (DATA_W - 1)) != 0) begin : g_bad_width
        $error("DATA_W must be a power of two of at least four");
    end

    // ---------------- link side, clocked by the serial clock ----------------
    logic              link_clr;
    logic [MODE_W-1:0] mode_meta_r;
    logic [MODE_W-1:0] mode_r;
    logic [DATA_W-1:0] rx_sh_r;
    logic [DATA_W-1:0] rx_word_r;
    logic [CNT_W-1:0]  rx_cnt_r;
    logic              rx_tgl_r;
    logic              seen_rise_r;
    logic [DATA_W-1:0] tx_sh_r;
    logic [CNT_W-1:0]  tx_left_r;
    logic [DATA_W-1:0] tx_byte_r;
    logic              dual_w;
    logic              load_w;

    // the frame's own select clears the link logic
    assign link_clr = cs_n || sys_rst; // R2 R4 R14
    assign dual_w   = mode_r[MODE_DUAL_IDX];
    assign load_w   = dual_w ? (tx_left_r == '0) : (rx_cnt_r == '0);

    // output enable and dual mode cross into the link domain
    always_ff @(posedge sck or posedge link_clr) begin
        if (link_clr) begin
            mode_meta_r <= '0;
            mode_r      <= '0;
        end else begin
            mode_meta_r <= {out_en, dual_en};
            mode_r      <= mode_meta_r;
        end
    end

    always_ff @(posedge sck or posedge link_clr) begin
        if (link_clr) begin
            rx_sh_r     <= '0;
            rx_cnt_r    <= '0; // R1 R14
            seen_rise_r <= 1'h0;
        end else if (hold_n) begin // R11
            seen_rise_r <= 1'h1;
            if (!dual_w) begin
                rx_sh_r  <= {rx_sh_r[DATA_W-2:0], dual_data_bit_zero_in}; // R6 R13
                rx_cnt_r <= rx_cnt_r + CNT_ONE;
            end
        end
    end

    // completed byte and its event toggle survive deselect
    always_ff @(posedge sck or posedge sys_rst) begin
        if (sys_rst) begin
            rx_word_r <= '0;
            rx_tgl_r  <= 1'h0;
        end else if (!cs_n && hold_n && !dual_w && rx_cnt_r == CNT_W'(DATA_W - 1)) begin
            rx_word_r <= {rx_sh_r[DATA_W-2:0], dual_data_bit_zero_in}; // R6 R13
            rx_tgl_r  <= ~rx_tgl_r;
        end
    end

    // falling edges before the first rising one are ignored, so mode 3 aligns
    always_ff @(negedge sck or posedge link_clr) begin
        if (link_clr) begin
            tx_sh_r            <= '0;
            tx_left_r          <= '0;
            dual_data_bit_one  <= 1'h0;
            dual_data_bit_zero <= 1'h0;
        end else if (hold_n && seen_rise_r) begin // R9 R11
            if (load_w && dual_w) begin
                dual_data_bit_one  <= tx_byte_r[DATA_W-1]; // R8
                dual_data_bit_zero <= tx_byte_r[DATA_W-2];
                tx_sh_r            <= tx_byte_r << DUAL_LANES;
                tx_left_r          <= DUAL_LAST;
            end else if (load_w) begin
                dual_data_bit_one  <= tx_byte_r[DATA_W-1]; // R7 R13
                tx_sh_r            <= tx_byte_r << 1;
            end else if (dual_w) begin
                dual_data_bit_one  <= tx_sh_r[DATA_W-1]; // R8
                dual_data_bit_zero <= tx_sh_r[DATA_W-2];
                tx_sh_r            <= tx_sh_r << DUAL_LANES;
                tx_left_r          <= tx_left_r - CNT_ONE;
            end else begin
                dual_data_bit_one  <= tx_sh_r[DATA_W-1]; // R7
                tx_sh_r            <= tx_sh_r << 1;
            end
        end
    end

    assign dual_data_bit_one_oe  = !cs_n && hold_n && mode_r[MODE_OE_IDX]; // R3 R11
    assign dual_data_bit_zero_oe = dual_data_bit_one_oe && dual_w; // R8

    // ---------------- core side ----------------
    logic [CDC_W-1:0] cdc_s;
    logic             cs_s;
    logic             tgl_s;
    logic             cs_d_r;
    logic             tgl_d_r;
    power_state_e     state_r;
    power_state_e     state_nxt;

    two_flop_sync #(
        .WIDTH (CDC_W)
    ) u_pin_sync (
        .clk (core_clk),
        .d   ({cs_n, rx_tgl_r}),
        .q   (cdc_s)
    );

    assign cs_s  = cdc_s[CDC_CS_IDX];
    assign tgl_s = cdc_s[CDC_TGL_IDX];

    // transmit byte stays stable between loads; link reads it at byte bounds
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            tx_byte_r <= '0;
        end else if (tx_load) begin
            tx_byte_r <= tx_byte;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cs_d_r      <= 1'h1;
            frame_start <= 1'h0;
            frame_end   <= 1'h0;
        end else begin
            cs_d_r      <= cs_s;
            frame_start <= cs_d_r && !cs_s; // R1
            frame_end   <= !cs_d_r && cs_s; // R2 R14
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            tgl_d_r  <= 1'h0;
            rx_valid <= 1'h0;
            rx_byte  <= '0;
        end else begin
            tgl_d_r  <= tgl_s;
            rx_valid <= tgl_d_r ^ tgl_s;
            if (tgl_d_r ^ tgl_s) begin
                rx_byte <= rx_word_r;
            end
        end
    end

    // pause never reaches this machine, so busy cycles run on
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_SELECTED: begin
                if (cs_s) begin
                    state_nxt = busy ? ST_FINISHING : ST_STANDBY; // R5
                end
            end
            ST_FINISHING: begin
                if (!cs_s) begin
                    state_nxt = ST_SELECTED;
                end else if (!busy) begin
                    state_nxt = ST_STANDBY; // R5 R12
                end
            end
            ST_STANDBY: begin
                if (!cs_s) begin
                    state_nxt = ST_SELECTED;
                end else if (busy) begin
                    state_nxt = ST_FINISHING;
                end
            end
            default: state_nxt = ST_STANDBY;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_r <= ST_STANDBY;
        end else begin
            state_r <= state_nxt; // R3
        end
    end

    assign selected = (state_r == ST_SELECTED);
    assign standby  = (state_r == ST_STANDBY);

    // ---------------- checks ----------------
    property p_r3_idle_hiz;
        @(posedge core_clk) disable iff (sys_rst)
        cs_n |-> !dual_data_bit_one_oe && !dual_data_bit_zero_oe;
    endproperty
    a_r3_idle_hiz: assert property (p_r3_idle_hiz) else $error("outputs driven while deselected"); // R3

    property p_r11_pause_hiz;
        @(posedge core_clk) disable iff (sys_rst)
        !hold_n |-> !dual_data_bit_one_oe && !dual_data_bit_zero_oe;
    endproperty
    a_r11_pause_hiz: assert property (p_r11_pause_hiz) else $error("outputs driven in pause"); // R11

    property p_r5_busy_blocks_standby;
        @(posedge core_clk) disable iff (sys_rst)
        (cs_s && busy) |=> !standby;
    endproperty
    a_r5_busy_blocks_standby: assert property (p_r5_busy_blocks_standby) else $error("standby while busy"); // R5

    property p_r1_start_pulse;
        @(posedge core_clk) disable iff (sys_rst)
        (cs_d_r && !cs_s) |=> frame_start ##1 !frame_start;
    endproperty
    a_r1_start_pulse: assert property (p_r1_start_pulse) else $error("frame start not flagged"); // R1

    property p_r2_end_to_idle;
        @(posedge core_clk) disable iff (sys_rst)
        (!cs_d_r && cs_s) |=> frame_end && !selected;
    endproperty
    a_r2_end_to_idle: assert property (p_r2_end_to_idle) else $error("frame end not flagged"); // R2

    property p_r6_byte_capture;
        @(posedge sck) disable iff (link_clr)
        (hold_n && !dual_w && rx_cnt_r == CNT_W'(DATA_W - 1))
            |=> rx_word_r == {$past(rx_sh_r[DATA_W-2:0]), $past(dual_data_bit_zero_in)};
    endproperty
    a_r6_byte_capture: assert property (p_r6_byte_capture) else $error("received byte wrong"); // R6

    property p_r14_fresh_count;
        @(posedge sck) disable iff (link_clr)
        !seen_rise_r |-> rx_cnt_r == '0;
    endproperty
    a_r14_fresh_count: assert property (p_r14_fresh_count) else $error("bit count not restarted"); // R14

    property p_r7_msb_out;
        @(negedge sck) disable iff (link_clr)
        (hold_n && seen_rise_r && load_w && !dual_w)
            |=> dual_data_bit_one == $past(tx_byte_r[DATA_W-1]);
    endproperty
    a_r7_msb_out: assert property (p_r7_msb_out) else $error("first output bit wrong"); // R7

    property p_r8_dual_pair;
        @(negedge sck) disable iff (link_clr)
        (hold_n && seen_rise_r && load_w && dual_w)
            |=> {dual_data_bit_one, dual_data_bit_zero} == $past(tx_byte_r[DATA_W-1:DATA_W-2]);
    endproperty
    a_r8_dual_pair: assert property (p_r8_dual_pair) else $error("dual pair wrong"); // R8

    property p_r9_no_early_shift;
        @(negedge sck) disable iff (link_clr)
        !seen_rise_r |=> tx_sh_r == '0;
    endproperty
    a_r9_no_early_shift: assert property (p_r9_no_early_shift) else $error("shift before rise"); // R9

    c_frame: cover property (@(posedge core_clk) disable iff (sys_rst) frame_start);
    c_byte: cover property (@(posedge core_clk) disable iff (sys_rst) rx_valid);
    c_dual: cover property (@(negedge sck) disable iff (link_clr) dual_w && load_w);
    c_finish: cover property (@(posedge core_clk) disable iff (sys_rst)
        state_r == ST_FINISHING ##1 standby);
endmodule : serial_flash_spi_front_end

// file: verilog/two_flop_sync.sv
`timescale 1ns/100ps
module two_flop_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_r;

    // first stage feeds only the second
    always_ff @(posedge clk) begin
        meta_r <= d;
        q      <= meta_r;
    end
endmodule : two_flop_sync
